// >>> rtl/smc_pkg.sv
// package: register map, field positions, reset values and carriers of the config bank
`default_nettype none
package smc_pkg;
   localparam logic [7:0] OFF_INIT_ADDR_LO  = 8'h5b;
   localparam logic [7:0] OFF_INIT_ADDR_HI  = 8'h5c;
   localparam logic [7:0] OFF_INIT_DATA     = 8'h5e;
   localparam logic [7:0] OFF_FAULT_FLAGS   = 8'h5f;
   localparam logic [7:0] OFF_PULLUP_TRIM   = 8'h68;
   localparam logic [7:0] OFF_RETRIM_CTRL   = 8'h69;
   localparam logic [7:0] OFF_NVM_CTRL      = 8'h6a;
   localparam logic [7:0] OFF_IF_CONFIG     = 8'h6b;
   localparam logic [7:0] OFF_PAD_DRIVE     = 8'h6c;

   localparam logic [7:0] RST_PULLUP_TRIM   = 8'h01;
   localparam logic [7:0] RST_PAD_DRIVE     = 8'haa;
   localparam logic [7:0] RST_ZERO          = 8'h00;

   localparam int         FAULT_SLOW_BIT    = 1;
   localparam int         FAULT_FATAL_BIT   = 2;
   localparam int         FAULT_ENGOFF_BIT  = 4;
   localparam int         RETRIM_RUN_BIT    = 2;
   localparam int         RETRIM_PACE_BIT   = 3;
   localparam int         NVM_PROG_BIT      = 1;
   localparam int         IF_PRI3W_BIT      = 0;
   localparam int         IF_STAB3W_BIT     = 1;
   localparam int         IF_STAB_EN_BIT    = 4;
   localparam int         IF_AUX_EN_BIT     = 5;
   localparam int         DRV_BOOST1_BIT    = 3;
   localparam int         DRV_BOOST2_BIT    = 7;

   localparam logic [7:0] MASK_INIT_ADDR_LO = 8'h0f;
   localparam logic [7:0] MASK_PULLUP_TRIM  = 8'h03;
   localparam logic [7:0] MASK_RETRIM_RW    = 8'h04;
   localparam logic [7:0] MASK_NVM_CTRL     = 8'h02;
   localparam logic [7:0] MASK_IF_CONFIG    = 8'h33;
   localparam logic [7:0] MASK_FAULT_FLAGS  = 8'h16;

   localparam int         WORD_ADDR_W       = 12;
   localparam logic [1:0] RESP_OKAY         = 2'b00;
   localparam logic [1:0] RESP_SLVERR       = 2'b10;

   typedef enum logic [1:0]
   {
      PULL_OFF = 2'h0,
      PULL_40K = 2'h1,
      PULL_10K = 2'h2,
      PULL_2K  = 2'h3
   } smc_pull_e;

   typedef enum logic [1:0]
   {
      SEC_NONE = 2'b00,
      SEC_STAB = 2'b01,
      SEC_AUX  = 2'b10
   } smc_sec_e;

   typedef struct packed
   {
      logic [WORD_ADDR_W-1:0] word_addr;
      logic                   low_byte;
      logic [7:0]             data;
   } smc_mem_wr_s;

   // field order follows the drive register, msb first, so the struct maps bit for bit
   typedef struct packed
   {
      logic       aux_pulldown_boost_off;
      logic [2:0] secondary_pad_strength;
      logic       primary_pulldown_boost_off;
      logic [2:0] primary_pad_strength;
   } smc_pad_s;

   typedef struct packed
   {
      logic     primary_three_wire_select;
      logic     stab_three_wire_select;
      smc_sec_e secondary_sel;
   } smc_if_s;
endpackage : smc_pkg
`default_nettype wire

// >>> rtl/smc_config_regs.sv
// register bank: init download port, fault flags, pad/interface config, over AXI4-Lite
// Contract
// - base address bits 11..4 held at 0x5C, read-write, reset zero
// - base address bits 3..0 held in low nibble of 0x5B, reset zero
// - bytes written to 0x5E go into memory from the base word address
// - fault bit 1 flags overlong processing and halts processing
// - fault bit 2 flags fatal internal error and halts processing
// - fault bit 4 flags engine disabled by host while operating
// - pull-up select 0x68: off, 40k, 10k, 2k; resets to 0x01
// - retrim bit 2 reads one while retrimming runs
// - retrim bit 3 is read-only pacer: 0 ongoing, 1 complete
// - 0x6A bit 1 enables non-volatile programming
// - 0x6B bit 0 selects primary three-wire over four-wire SPI
// - 0x6B bit 1 selects stabilization interface three-wire SPI
// - bit 5 aux enable outranks bit 4 stabilization enable
// - 0x6C bits 2..0 primary pad strength, resets to 0xAA
// - 0x6C bits 6..4 secondary pad strength, same scale
// - 0x6C bits 3 and 7 disable extra I2C pull-down strength
//
// Implementation choice: the AXI4-Lite interface to the registers.
`default_nettype none
module smc_config_regs
   import smc_pkg::*;
(
   input  wire  logic                CORE_CLK,
   input  wire  logic                RST,
   input  wire  logic [31:0]         S_AWADDR,
   input  wire  logic                S_AWVALID,
   output logic                      S_AWREADY,
   input  wire  logic [31:0]         S_WDATA,
   input  wire  logic [3:0]          S_WSTRB,
   input  wire  logic                S_WVALID,
   output logic                      S_WREADY,
   output logic [1:0]                S_BRESP,
   output logic                      S_BVALID,
   input  wire  logic                S_BREADY,
   input  wire  logic [31:0]         S_ARADDR,
   input  wire  logic                S_ARVALID,
   output logic                      S_ARREADY,
   output logic [31:0]               S_RDATA,
   output logic [1:0]                S_RRESP,
   output logic                      S_RVALID,
   input  wire  logic                S_RREADY,
   input  wire  logic                SLOW_PROC_EVT,
   input  wire  logic                FATAL_ERR_EVT,
   input  wire  logic                ENGINE_OFF_EVT,
   input  wire  logic                RETRIM_DONE,
   input  wire  logic                RETRIM_STEP_DONE,
   output logic                      PROC_HALT,
   output smc_pkg::smc_mem_wr_s      MEM_WR,
   output logic                      MEM_WR_EN,
   output smc_pkg::smc_pull_e        AUX_PULLUP_SEL,
   output logic                      RETRIM_RUN,
   output logic                      NVM_PROG_EN,
   output smc_pkg::smc_if_s          IF_SEL,
   output smc_pkg::smc_pad_s         PAD_CFG
);
   import smc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////////
   // write channel capture: address and data accepted in either order
   logic [7:0]            aw_idx_ff;
   logic                  aw_have_ff;
   logic [7:0]            wd_ff;
   logic                  wd_strb_ff;
   logic                  wd_have_ff;
   logic                  bvalid_ff;
   logic [1:0]            bresp_ff;
   logic                  rvalid_ff;
   logic [31:0]           rdata_ff;
   logic [1:0]            rresp_ff;

   wire                   aw_take = S_AWVALID && S_AWREADY;
   wire                   w_take  = S_WVALID && S_WREADY;
   wire                   wr_go   = aw_have_ff && wd_have_ff && !bvalid_ff;
   wire                   ar_take = S_ARVALID && S_ARREADY;

   assign S_AWREADY = !aw_have_ff && !bvalid_ff;
   assign S_WREADY  = !wd_have_ff && !bvalid_ff;
   assign S_ARREADY = !rvalid_ff;
   assign S_BVALID  = bvalid_ff;
   assign S_BRESP   = bresp_ff;
   assign S_RVALID  = rvalid_ff;
   assign S_RDATA   = rdata_ff;
   assign S_RRESP   = rresp_ff;

   // only byte lane 0 carries a register; upper address bits must be zero
   wire                   aw_in_range = (S_AWADDR[31:10] == 22'h0) && (S_AWADDR[1:0] == 2'h0);
   wire                   ar_in_range = (S_ARADDR[31:10] == 22'h0) && (S_ARADDR[1:0] == 2'h0);
   logic                  aw_ok_ff;

   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         aw_have_ff <= 1'b0;
         aw_idx_ff  <= 8'h00;
         aw_ok_ff   <= 1'b0;
      end
      else if (aw_take)
      begin
         aw_have_ff <= 1'b1;
         aw_idx_ff  <= S_AWADDR[9:2];
         aw_ok_ff   <= aw_in_range;
      end
      else if (wr_go)
         aw_have_ff <= 1'b0;
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         wd_have_ff <= 1'b0;
         wd_ff      <= 8'h00;
         wd_strb_ff <= 1'b0;
      end
      else if (w_take)
      begin
         wd_have_ff <= 1'b1;
         wd_ff      <= S_WDATA[7:0];
         wd_strb_ff <= S_WSTRB[0];
      end
      else if (wr_go)
         wd_have_ff <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // write decode
   wire                   wr_hit_ok = wr_go && aw_ok_ff;
   wire                   wr_en     = wr_hit_ok && wd_strb_ff;
   wire                   wsel_alo  = wr_en && (aw_idx_ff == OFF_INIT_ADDR_LO);
   wire                   wsel_ahi  = wr_en && (aw_idx_ff == OFF_INIT_ADDR_HI);
   wire                   wsel_dat  = wr_en && (aw_idx_ff == OFF_INIT_DATA);
   wire                   wsel_pull = wr_en && (aw_idx_ff == OFF_PULLUP_TRIM);
   wire                   wsel_rtr  = wr_en && (aw_idx_ff == OFF_RETRIM_CTRL);
   wire                   wsel_nvm  = wr_en && (aw_idx_ff == OFF_NVM_CTRL);
   wire                   wsel_if   = wr_en && (aw_idx_ff == OFF_IF_CONFIG);
   wire                   wsel_drv  = wr_en && (aw_idx_ff == OFF_PAD_DRIVE);
   wire                   w_mapped  = (aw_idx_ff == OFF_INIT_ADDR_LO) ||
                                      (aw_idx_ff == OFF_INIT_ADDR_HI) ||
                                      (aw_idx_ff == OFF_INIT_DATA)    ||
                                      (aw_idx_ff == OFF_FAULT_FLAGS)  ||
                                      (aw_idx_ff == OFF_PULLUP_TRIM)  ||
                                      (aw_idx_ff == OFF_RETRIM_CTRL)  ||
                                      (aw_idx_ff == OFF_NVM_CTRL)     ||
                                      (aw_idx_ff == OFF_IF_CONFIG)    ||
                                      (aw_idx_ff == OFF_PAD_DRIVE);

   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= RESP_OKAY;
      end
      else if (wr_go)
      begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= (aw_ok_ff && w_mapped) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (S_BREADY)
         bvalid_ff <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // storage
   logic [7:0]            addr_lo_ff;
   logic [7:0]            addr_hi_ff;
   logic [7:0]            data_port_ff;
   logic [7:0]            pull_ff;
   logic                  run_ff;
   logic                  pace_ff;
   logic [7:0]            nvm_ff;
   logic [7:0]            if_ff;
   logic [7:0]            drv_ff;
   logic [7:0]            fault_ff;
   logic                  hi_byte_ff;
   logic [WORD_ADDR_W-1:0] wptr_ff;
   logic                  wr_en_ff;
   smc_mem_wr_s           mem_wr_ff;

   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         addr_lo_ff <= RST_ZERO;
         addr_hi_ff <= RST_ZERO;
         pull_ff    <= RST_PULLUP_TRIM;
         nvm_ff     <= RST_ZERO;
         if_ff      <= RST_ZERO;
         drv_ff     <= RST_PAD_DRIVE;
      end
      else
      begin
         if (wsel_alo)
            addr_lo_ff <= wd_ff & MASK_INIT_ADDR_LO;
         if (wsel_ahi)
            addr_hi_ff <= wd_ff;
         if (wsel_pull)
            pull_ff <= wd_ff & MASK_PULLUP_TRIM;
         if (wsel_nvm)
            nvm_ff <= wd_ff & MASK_NVM_CTRL;
         if (wsel_if)
            if_ff <= wd_ff & MASK_IF_CONFIG;
         if (wsel_drv)
            drv_ff <= wd_ff;
      end
   end

   // retrim run bit: software starts it, completion clears it; a start wins over done
   // pacer: a finished step wins over a restart, so a completion is never lost
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         run_ff  <= 1'b0;
         pace_ff <= 1'b0;
      end
      else
      begin
         if (wsel_rtr)
            run_ff <= wd_ff[RETRIM_RUN_BIT];
         else if (RETRIM_DONE)
            run_ff <= 1'b0;
         if (RETRIM_STEP_DONE)
            pace_ff <= 1'b1;
         else if (wsel_rtr && wd_ff[RETRIM_RUN_BIT])
            pace_ff <= 1'b0;
      end
   end

   // fault flags are sticky until reset; nothing in this bank clears them
   wire [7:0]             fault_set = {3'h0, ENGINE_OFF_EVT, 1'b0, FATAL_ERR_EVT, SLOW_PROC_EVT, 1'b0};

   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
         fault_ff <= RST_ZERO;
      else
         fault_ff <= fault_ff | (fault_set & MASK_FAULT_FLAGS);
   end

   assign PROC_HALT = fault_ff[FAULT_SLOW_BIT] || fault_ff[FAULT_FATAL_BIT];

   ////////////////////////////////////////////////////////////////////////////////////
   // init download: bytes pair into 16-bit words, low byte first, pointer reloads from base
   wire [WORD_ADDR_W-1:0] base_addr = {addr_hi_ff, addr_lo_ff[3:0]};
   wire                   base_wr   = wsel_alo || wsel_ahi;

   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         wptr_ff      <= '0;
         hi_byte_ff   <= 1'b0;
         data_port_ff <= RST_ZERO;
         wr_en_ff     <= 1'b0;
         mem_wr_ff    <= '0;
      end
      else
      begin
         wr_en_ff <= wsel_dat;
         if (base_wr)
         begin
            wptr_ff    <= '0;
            hi_byte_ff <= 1'b0;
         end
         else if (wsel_dat)
         begin
            data_port_ff <= wd_ff;
            mem_wr_ff    <= '{word_addr: base_addr + wptr_ff, low_byte: !hi_byte_ff, data: wd_ff};
            hi_byte_ff   <= !hi_byte_ff;
            if (hi_byte_ff)
               wptr_ff <= wptr_ff + 12'h001;
         end
      end
   end

   assign MEM_WR    = mem_wr_ff;
   assign MEM_WR_EN = wr_en_ff;

   ////////////////////////////////////////////////////////////////////////////////////
   // configuration outputs
   assign AUX_PULLUP_SEL = smc_pull_e'(pull_ff[1:0]);
   assign RETRIM_RUN     = run_ff;
   assign NVM_PROG_EN    = nvm_ff[NVM_PROG_BIT];

   wire                   aux_on  = if_ff[IF_AUX_EN_BIT];
   wire                   stab_on = if_ff[IF_STAB_EN_BIT] && !aux_on;

   smc_sec_e              sec_sel;

   assign sec_sel = aux_on ? SEC_AUX : (stab_on ? SEC_STAB : SEC_NONE);
   // one driver for the whole struct keeps the port single-sourced
   assign IF_SEL  = '{primary_three_wire_select: if_ff[IF_PRI3W_BIT],
                      stab_three_wire_select: stab_on && if_ff[IF_STAB3W_BIT],
                      secondary_sel: sec_sel};

   assign PAD_CFG = drv_ff;

   ////////////////////////////////////////////////////////////////////////////////////
   // read path: one-cycle answer, data registered
   logic [7:0]            rd_mux;
   logic                  rd_hit;
   wire  [7:0]            ar_idx = S_ARADDR[9:2];
   wire  [7:0]            retrim_rd = {4'h0, pace_ff, run_ff, 2'h0};

   always_comb
   begin
      rd_hit = ar_in_range;
      case (ar_idx)
         OFF_INIT_ADDR_LO : rd_mux = addr_lo_ff;
         OFF_INIT_ADDR_HI : rd_mux = addr_hi_ff;
         OFF_INIT_DATA    : rd_mux = data_port_ff;
         OFF_FAULT_FLAGS  : rd_mux = fault_ff;
         OFF_PULLUP_TRIM  : rd_mux = pull_ff;
         OFF_RETRIM_CTRL  : rd_mux = retrim_rd;
         OFF_NVM_CTRL     : rd_mux = nvm_ff;
         OFF_IF_CONFIG    : rd_mux = if_ff;
         OFF_PAD_DRIVE    : rd_mux = drv_ff;
         default          :
         begin
            rd_mux = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h0000_0000;
         rresp_ff  <= RESP_OKAY;
      end
      else if (ar_take)
      begin
         rvalid_ff <= 1'b1;
         rdata_ff  <= {24'h00_0000, rd_hit ? rd_mux : 8'h00};
         rresp_ff  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (S_RREADY)
         rvalid_ff <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // checks
   sticky_fault_a : assert property (@(posedge CORE_CLK) disable iff (RST)
      SLOW_PROC_EVT |=> fault_ff[FAULT_SLOW_BIT] ##1 fault_ff[FAULT_SLOW_BIT])
      else $error("slow processing flag not held");
   fatal_halt_a : assert property (@(posedge CORE_CLK) disable iff (RST)
      FATAL_ERR_EVT |=> PROC_HALT[*3])
      else $error("fatal error did not halt processing");
   engine_off_a : assert property (@(posedge CORE_CLK) disable iff (RST)
      ENGINE_OFF_EVT |=> fault_ff[FAULT_ENGOFF_BIT])
      else $error("engine off flag missing");
   aux_priority_a : assert property (@(posedge CORE_CLK) disable iff (RST)
      if_ff[IF_AUX_EN_BIT] |-> IF_SEL.secondary_sel == SEC_AUX && !IF_SEL.stab_three_wire_select)
      else $error("aux enable lost priority");
   base_hi_write_a : assert property (@(posedge CORE_CLK) disable iff (RST)
      wsel_ahi |=> addr_hi_ff == $past(wd_ff))
      else $error("base high byte not stored");
   data_place_a : assert property (@(posedge CORE_CLK) disable iff (RST)
      (wsel_dat && wptr_ff == 12'h000 && !hi_byte_ff) |=> MEM_WR_EN && MEM_WR.low_byte
      && MEM_WR.word_addr == $past(base_addr))
      else $error("first byte not at base address");
   reserved_zero_a : assert property (@(posedge CORE_CLK) disable iff (RST)
      rvalid_ff |-> rdata_ff[31:8] == 24'h0 && (fault_ff & ~MASK_FAULT_FLAGS) == 8'h0)
      else $error("reserved bits not zero");
   pace_step_a : assert property (@(posedge CORE_CLK) disable iff (RST)
      RETRIM_STEP_DONE |=> retrim_rd[RETRIM_PACE_BIT])
      else $error("pacer bit not set after step");
   nvm_gate_a : assert property (@(posedge CORE_CLK) disable iff (RST)
      wsel_nvm |=> NVM_PROG_EN == $past(wd_ff[NVM_PROG_BIT]))
      else $error("nvm enable not following write");
   run_clear_a : assert property (@(posedge CORE_CLK) disable iff (RST)
      (RETRIM_DONE && !wsel_rtr) |=> !RETRIM_RUN)
      else $error("retrim run not cleared");
endmodule : smc_config_regs
`default_nettype wire

// >>> verif/smc_config_regs_tb.sv
// self-checking bench of the config register bank, driven over AXI4-Lite
`default_nettype none
module smc_config_regs_tb
   import smc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic              CORE_CLK, RST;
   logic [31:0]       S_AWADDR, S_WDATA, S_ARADDR, S_RDATA;
   logic [3:0]        S_WSTRB;
   logic [1:0]        S_BRESP, S_RRESP;
   logic              S_AWVALID, S_AWREADY, S_WVALID, S_WREADY, S_BVALID, S_BREADY;
   logic              S_ARVALID, S_ARREADY, S_RVALID, S_RREADY;
   logic              SLOW_PROC_EVT, FATAL_ERR_EVT, ENGINE_OFF_EVT;
   logic              RETRIM_DONE, RETRIM_STEP_DONE, PROC_HALT, MEM_WR_EN;
   logic              RETRIM_RUN, NVM_PROG_EN;
   smc_mem_wr_s       MEM_WR;
   smc_pull_e         AUX_PULLUP_SEL;
   smc_if_s           IF_SEL;
   smc_pad_s          PAD_CFG;
   int                errors, total_checks;
   smc_mem_wr_s       memq[$];

   smc_config_regs i_smc_config_regs (.CORE_CLK(CORE_CLK), .RST(RST), .S_AWADDR(S_AWADDR),
      .S_AWVALID(S_AWVALID), .S_AWREADY(S_AWREADY), .S_WDATA(S_WDATA), .S_WSTRB(S_WSTRB),
      .S_WVALID(S_WVALID), .S_WREADY(S_WREADY), .S_BRESP(S_BRESP), .S_BVALID(S_BVALID),
      .S_BREADY(S_BREADY), .S_ARADDR(S_ARADDR), .S_ARVALID(S_ARVALID), .S_ARREADY(S_ARREADY),
      .S_RDATA(S_RDATA), .S_RRESP(S_RRESP), .S_RVALID(S_RVALID), .S_RREADY(S_RREADY),
      .SLOW_PROC_EVT(SLOW_PROC_EVT), .FATAL_ERR_EVT(FATAL_ERR_EVT),
      .ENGINE_OFF_EVT(ENGINE_OFF_EVT), .RETRIM_DONE(RETRIM_DONE),
      .RETRIM_STEP_DONE(RETRIM_STEP_DONE), .PROC_HALT(PROC_HALT), .MEM_WR(MEM_WR),
      .MEM_WR_EN(MEM_WR_EN), .AUX_PULLUP_SEL(AUX_PULLUP_SEL), .RETRIM_RUN(RETRIM_RUN),
      .NVM_PROG_EN(NVM_PROG_EN), .IF_SEL(IF_SEL), .PAD_CFG(PAD_CFG));

   initial
   begin
      CORE_CLK = 1'b0;
      forever #5 CORE_CLK = ~CORE_CLK;
   end

   // memory write strobe is a one-cycle pulse, so it is captured at every edge
   always @(posedge CORE_CLK)
      if (MEM_WR_EN === 1'b1) memq.push_back(MEM_WR);

   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // bready and rready stay high, so each task ends on the response edge
   task automatic wr(input logic [31:0] a, input logic [7:0] d, output logic [1:0] r);
      S_AWADDR  <= a;
      S_WDATA   <= {24'h0, d};
      S_AWVALID <= 1'b1;
      S_WVALID  <= 1'b1;
      for (int n = 0; n < 40; n++)
      begin
         @(posedge CORE_CLK);
         if (S_AWREADY === 1'b1) S_AWVALID <= 1'b0;
         if (S_WREADY === 1'b1) S_WVALID <= 1'b0;
         if (S_BVALID === 1'b1)
         begin
            r = S_BRESP;
            return;
         end
      end
      errors++;
      finish_test();
   endtask : wr

   task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      S_ARADDR  <= a;
      S_ARVALID <= 1'b1;
      for (int n = 0; n < 40; n++)
      begin
         @(posedge CORE_CLK);
         if (S_ARREADY === 1'b1) S_ARVALID <= 1'b0;
         if (S_RVALID === 1'b1)
         begin
            d = S_RDATA;
            r = S_RRESP;
            return;
         end
      end
      errors++;
      finish_test();
   endtask : rd

   task automatic wchk(input logic [7:0] off, input logic [7:0] d);
      logic [1:0] r;
      wr({22'h0, off, 2'b00}, d, r);
      chk(r, RESP_OKAY);
   endtask : wchk

   task automatic rchk(input logic [7:0] off, input logic [7:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      rd({22'h0, off, 2'b00}, d, r);
      chk(r, RESP_OKAY);
      chk(d, {24'h0, exp});
   endtask : rchk

   task automatic pulse(input int k);
      SLOW_PROC_EVT    <= (k == 0);
      FATAL_ERR_EVT    <= (k == 1);
      ENGINE_OFF_EVT   <= (k == 2);
      RETRIM_DONE      <= (k == 3);
      RETRIM_STEP_DONE <= (k == 4);
      @(posedge CORE_CLK);
      {SLOW_PROC_EVT, FATAL_ERR_EVT, ENGINE_OFF_EVT, RETRIM_DONE, RETRIM_STEP_DONE} <= 5'h00;
      @(posedge CORE_CLK);
   endtask : pulse

   task automatic do_reset;
      RST <= 1'b1;
      repeat (20) @(posedge CORE_CLK);
      RST <= 1'b0;
      @(posedge CORE_CLK);
   endtask : do_reset

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      chk(PAD_CFG, RST_PAD_DRIVE);
      chk(AUX_PULLUP_SEL, PULL_40K);
      rchk(OFF_INIT_ADDR_LO, 8'h00);
      rchk(OFF_INIT_ADDR_HI, 8'h00);
      rchk(OFF_FAULT_FLAGS, 8'h00);
      rchk(OFF_PULLUP_TRIM, 8'h01);
      rchk(OFF_PAD_DRIVE, 8'haa);
      rchk(OFF_IF_CONFIG, 8'h00);
   endtask : t_reset

   task automatic t_rw;
      logic [7:0] offs[6] = '{OFF_INIT_ADDR_LO, OFF_INIT_ADDR_HI, OFF_PULLUP_TRIM,
                              OFF_NVM_CTRL, OFF_IF_CONFIG, OFF_PAD_DRIVE};
      logic [7:0] exps[6] = '{8'h0f, 8'hff, 8'h03, 8'h02, 8'h33, 8'hff};
      for (int i = 0; i < 6; i++)
      begin
         wchk(offs[i], 8'hff);
         rchk(offs[i], exps[i]);
      end
      chk(NVM_PROG_EN, 1'b1);
      wchk(OFF_NVM_CTRL, 8'hfd);
      chk(NVM_PROG_EN, 1'b0);
      for (int v = 0; v < 4; v++)
      begin
         wchk(OFF_PULLUP_TRIM, v[7:0]);
         chk(AUX_PULLUP_SEL, v[1:0]);
      end
      // an asymmetric pattern so a swapped field order cannot pass
      wchk(OFF_PAD_DRIVE, 8'h3c);
      chk(PAD_CFG.primary_pad_strength, 3'h4);
      chk(PAD_CFG.secondary_pad_strength, 3'h3);
      chk({PAD_CFG.aux_pulldown_boost_off, PAD_CFG.primary_pulldown_boost_off}, 2'b01);
      wchk(OFF_PAD_DRIVE, 8'h5a);
      chk(PAD_CFG.primary_pad_strength, 3'h2);
      chk(PAD_CFG.secondary_pad_strength, 3'h5);
      chk({PAD_CFG.aux_pulldown_boost_off, PAD_CFG.primary_pulldown_boost_off}, 2'b01);
   endtask : t_rw

   task automatic t_if;
      logic [7:0] wv[5] = '{8'h00, 8'h13, 8'h12, 8'h33, 8'h03};
      logic [3:0] ev[5] = '{4'h0, 4'hd, 4'h5, 4'ha, 4'h8};
      for (int i = 0; i < 5; i++)
      begin
         wchk(OFF_IF_CONFIG, wv[i]);
         chk(IF_SEL, ev[i]);
      end
   endtask : t_if

   task automatic t_init;
      smc_mem_wr_s ex[5] = '{'{12'h123, 1'b1, 8'ha1}, '{12'h123, 1'b0, 8'hb2},
                             '{12'h124, 1'b1, 8'hc3}, '{12'h124, 1'b0, 8'hd4},
                             '{12'h125, 1'b1, 8'he5}};
      memq.delete();
      wchk(OFF_INIT_ADDR_LO, 8'h03);
      wchk(OFF_INIT_ADDR_HI, 8'h12);
      wchk(OFF_INIT_DATA, 8'ha1);
      wchk(OFF_INIT_DATA, 8'hb2);
      // two bytes went out, so the host moves the base on by one word
      wchk(OFF_INIT_ADDR_LO, 8'h04);
      wchk(OFF_INIT_DATA, 8'hc3);
      wchk(OFF_INIT_DATA, 8'hd4);
      // a longer burst runs on from the same base with no update
      wchk(OFF_INIT_DATA, 8'he5);
      repeat (3) @(posedge CORE_CLK);
      chk(memq.size(), 5);
      for (int i = 0; i < 5 && i < memq.size(); i++)
         chk({11'h0, memq[i]}, {11'h0, ex[i]});
      rchk(OFF_INIT_ADDR_HI, 8'h12);
      rchk(OFF_INIT_ADDR_LO, 8'h04);
      rchk(OFF_INIT_DATA, 8'he5);
   endtask : t_init

   task automatic t_retrim;
      wchk(OFF_RETRIM_CTRL, 8'h04);
      chk(RETRIM_RUN, 1'b1);
      rchk(OFF_RETRIM_CTRL, 8'h04);
      pulse(4);
      rchk(OFF_RETRIM_CTRL, 8'h0c);
      pulse(3);
      chk(RETRIM_RUN, 1'b0);
      wchk(OFF_RETRIM_CTRL, 8'hf0);
      rchk(OFF_RETRIM_CTRL, 8'h08);
   endtask : t_retrim

   task automatic t_err;
      logic [31:0] d;
      logic [1:0]  r;
      rd(32'h0000_03fc, d, r);
      chk(r, RESP_SLVERR);
      chk(d, 32'h0);
      wr(32'h0000_01b1, 8'h00, r);
      chk(r, RESP_SLVERR);
      chk(PAD_CFG, 8'h5a);
      // byte lane 0 disabled: the write is answered but nothing is stored
      S_WSTRB <= 4'he;
      wchk(OFF_PAD_DRIVE, 8'h00);
      S_WSTRB <= 4'hf;
      chk(PAD_CFG, 8'h5a);
   endtask : t_err

   task automatic t_fault;
      logic [31:0] d;
      logic [1:0]  r;
      chk(PROC_HALT, 1'b0);
      pulse(2);
      rchk(OFF_FAULT_FLAGS, 8'h10);
      chk(PROC_HALT, 1'b0);
      pulse(0);
      rchk(OFF_FAULT_FLAGS, 8'h12);
      chk(PROC_HALT, 1'b1);
      wchk(OFF_FAULT_FLAGS, 8'hff);
      // host view: only the defined flag positions are looked at
      rd({22'h0, OFF_FAULT_FLAGS, 2'b00}, d, r);
      chk(d[7:0] & MASK_FAULT_FLAGS, 8'h12);
      rchk(OFF_FAULT_FLAGS, 8'h12);
      do_reset();
      chk(PROC_HALT, 1'b0);
      pulse(1);
      rchk(OFF_FAULT_FLAGS, 8'h04);
      chk(PROC_HALT, 1'b1);
   endtask : t_fault

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      errors = 0;
      total_checks = 0;
      {S_AWADDR, S_WDATA, S_ARADDR} = '0;
      {S_AWVALID, S_WVALID, S_ARVALID} = 3'b000;
      S_WSTRB = 4'hf;
      {S_BREADY, S_RREADY} = 2'b11;
      {SLOW_PROC_EVT, FATAL_ERR_EVT, ENGINE_OFF_EVT, RETRIM_DONE, RETRIM_STEP_DONE} = 5'h00;
      RST = 1'b1;
      @(posedge CORE_CLK);
      do_reset();
      t_reset();
      t_rw();
      t_if();
      t_init();
      t_retrim();
      t_err();
      t_fault();
      finish_test();
   end
endmodule : smc_config_regs_tb
`default_nettype wire
